/* File: design/pscp_pkg.sv */
package pscp_pkg;
   // ***************************************************************
   // Word format
   // ***************************************************************
   localparam int unsigned WORD_BITS  = 24;
   localparam int unsigned CMD_MSB    = 23;
   localparam int unsigned CMD_LSB    = 20;
   localparam int unsigned ADDR_MSB   = 19;
   localparam int unsigned ADDR_LSB   = 16;
   localparam int unsigned DATA_MSB   = 15;
   localparam int unsigned WIPER_BITS = 10;
   localparam int unsigned NV_WORDS   = 16;
   localparam int unsigned NV_BITS    = 16;
   localparam logic [4:0]  FULL_COUNT = 5'h18;

   // ***************************************************************
   // Command codes
   // ***************************************************************
   localparam logic [3:0] CMD_NOP       = 4'h0;
   localparam logic [3:0] CMD_RESTORE   = 4'h1;
   localparam logic [3:0] CMD_SAVE      = 4'h2;
   localparam logic [3:0] CMD_NV_WRITE  = 4'h3;
   localparam logic [3:0] CMD_SHR       = 4'h4;
   localparam logic [3:0] CMD_SHR_ANY   = 4'h5;
   localparam logic [3:0] CMD_DEC       = 4'h6;
   localparam logic [3:0] CMD_DEC_ANY   = 4'h7;
   localparam logic [3:0] CMD_RESET     = 4'h8;
   localparam logic [3:0] CMD_RD_NV     = 4'h9;
   localparam logic [3:0] CMD_RD_WIPER  = 4'ha;
   localparam logic [3:0] CMD_WR_WIPER  = 4'hb;
   localparam logic [3:0] CMD_SHL       = 4'hc;
   localparam logic [3:0] CMD_SHL_ANY   = 4'hd;
   localparam logic [3:0] CMD_INC       = 4'he;
   localparam logic [3:0] CMD_INC_ANY   = 4'hf;

   // ***************************************************************
   // Store layout and reset values
   // ***************************************************************
   localparam logic [3:0]  NV_WIPER_ADDR  = 4'h0;
   localparam logic [3:0]  NV_LATCH_ADDR  = 4'h1;
   localparam int unsigned LATCH_ONE_BIT  = 0;
   localparam int unsigned LATCH_TWO_BIT  = 1;
   localparam logic [9:0]  WIPER_FACTORY  = 10'h200;
   localparam logic [9:0]  WIPER_MID      = 10'h200;
   localparam logic [9:0]  WIPER_FULL     = 10'h3ff;
   localparam logic [9:0]  WIPER_ZERO     = 10'h000;
   localparam logic [9:0]  WIPER_ONE      = 10'h001;
   localparam logic [15:0] NV_FACTORY     = 16'h0000;

   // ***************************************************************
   // Timing
   // ***************************************************************
   localparam int unsigned CLK_HZ       = 40_000_000;
   localparam int unsigned SAVE_TIME_MS = 25;
   localparam int unsigned SAVE_CYCLES  = (CLK_HZ / 1000) * SAVE_TIME_MS;
   localparam int unsigned BUSY_BITS    = 21;
endpackage : pscp_pkg

/* File: design/pscp_sync.sv */
`timescale 1ns/1ps
module pscp_sync #(
   parameter int unsigned WIDTH = 3
) (
   input  wire logic             clk_in,
   input  wire logic             rst_in,
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] stage1_reg;

   // First stage feeds only the second one
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         stage1_reg <= '0;
         sync_out   <= '0;
      end else begin
         stage1_reg <= async_in;
         sync_out   <= stage1_reg;
      end
   end
endmodule : pscp_sync

/* File: design/pscp_top.sv */
`timescale 1ns/1ps
module pscp_top #(
   parameter int unsigned SAVE_CYCLES = pscp_pkg::SAVE_CYCLES
) (
   input  wire logic       clk_in,
   input  wire logic       rst_in,
   input  wire logic       factory_init_in,
   input  wire logic       link_clk_in,
   input  wire logic       chip_select_n_in,
   input  wire logic       serial_in_pin_in,
   output logic            serial_out_pin_out,
   output logic            serial_out_pin_oe_out,
   output logic            ready_out,
   output logic            read_program_out,
   output logic [9:0]      wiper_setting_out,
   output logic            latched_output_one_out,
   output logic            latched_output_two_out
);
   // ***************************************************************
   // Types and declarations
   // ***************************************************************
   typedef enum logic [3:0] {
      ST_IDLE  = 4'h1,
      ST_SHIFT = 4'h2,
      ST_EXEC  = 4'h4,
      ST_BUSY  = 4'h8
   } pscp_state_e;

   pscp_state_e                        state_reg;
   logic [2:0]                         sync_q;
   logic                               sclk_s;
   logic                               cs_n_s;
   logic                               sdi_s;
   logic                               sclk_prev_reg;
   logic                               cs_n_prev_reg;
   logic                               sclk_rise;
   logic                               sclk_fall;
   logic                               cs_fall;
   logic                               cs_rise;
   logic [pscp_pkg::WORD_BITS-1:0]     shift_reg;
   logic [4:0]                         bit_cnt_reg;
   logic [3:0]                         cmd_reg;
   logic [3:0]                         addr_reg;
   logic [15:0]                        data_reg;
   logic [3:0]                         last_cmd_reg;
   logic                               repeat_ok_reg;
   logic [9:0]                         wiper_reg;
   logic [15:0]                        nv_reg [pscp_pkg::NV_WORDS];
   logic [pscp_pkg::BUSY_BITS-1:0]     busy_cnt_reg;
   logic                               sdo_bit_reg;
   logic                               word_ok;
   logic                               bare_strobe;

   // Wiper commands accept address 0 or 1 only; the _ANY forms, CMD_NOP, CMD_RESET, CMD_NV_WRITE and CMD_RD_NV accept any address
   function automatic logic pscp_wiper_addr_ok(input logic [3:0] cmd, input logic [3:0] addr);
      logic any_addr;
      any_addr = (cmd == pscp_pkg::CMD_SHR_ANY) || (cmd == pscp_pkg::CMD_DEC_ANY) ||
                 (cmd == pscp_pkg::CMD_SHL_ANY) || (cmd == pscp_pkg::CMD_INC_ANY) ||
                 (cmd == pscp_pkg::CMD_NOP) || (cmd == pscp_pkg::CMD_RESET) ||
                 (cmd == pscp_pkg::CMD_NV_WRITE) || (cmd == pscp_pkg::CMD_RD_NV);
      return any_addr || (addr[3:1] == 3'h0);
   endfunction : pscp_wiper_addr_ok

   function automatic logic pscp_is_step(input logic [3:0] cmd);
      return (cmd[3:2] == 2'b01) || (cmd[3:2] == 2'b11);
   endfunction : pscp_is_step

   // ***************************************************************
   // Pin sampling and edges
   // ***************************************************************
   pscp_sync #(
      .WIDTH    (3)
   ) u_sync (
      .clk_in   (clk_in),
      .rst_in   (rst_in),
      .async_in ({serial_in_pin_in, chip_select_n_in, link_clk_in}),
      .sync_out (sync_q)
   );

   assign sclk_s = sync_q[0];
   assign cs_n_s = sync_q[1];
   assign sdi_s  = sync_q[2];

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         sclk_prev_reg <= 1'b0;
         cs_n_prev_reg <= 1'b1;
      end else begin
         sclk_prev_reg <= sclk_s;
         cs_n_prev_reg <= cs_n_s;
      end
   end

   // Both modes sample on the rising edge and change data on the falling one
   assign sclk_rise = sclk_s & ~sclk_prev_reg;
   assign sclk_fall = ~sclk_s & sclk_prev_reg;
   assign cs_fall   = ~cs_n_s & cs_n_prev_reg;
   assign cs_rise   = cs_n_s & ~cs_n_prev_reg;

   // Only a full word, or a bare strobe after a step command, is acted on
   assign word_ok     = (bit_cnt_reg == pscp_pkg::FULL_COUNT);
   assign bare_strobe = (bit_cnt_reg == 5'h00) && repeat_ok_reg;

   // ***************************************************************
   // Control sequence
   // ***************************************************************
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         state_reg    <= ST_IDLE;
         busy_cnt_reg <= '0;
      end else begin
         case (state_reg)
            ST_IDLE: begin
               if (cs_fall) begin
                  state_reg <= ST_SHIFT;
               end
            end
            ST_SHIFT: begin
               if (cs_rise) begin
                  state_reg <= (word_ok || bare_strobe) ? ST_EXEC : ST_IDLE;
               end
            end
            ST_EXEC: begin
               if ((cmd_reg == pscp_pkg::CMD_SAVE || cmd_reg == pscp_pkg::CMD_NV_WRITE) &&
                   pscp_wiper_addr_ok(cmd_reg, addr_reg)) begin
                  state_reg    <= ST_BUSY;
                  busy_cnt_reg <= pscp_pkg::BUSY_BITS'(SAVE_CYCLES - 1);
               end else begin
                  state_reg <= ST_IDLE;
               end
            end
            ST_BUSY: begin
               // Shift register stays locked until the save time runs out
               if (busy_cnt_reg == '0) begin
                  state_reg <= ST_IDLE;
               end else begin
                  busy_cnt_reg <= busy_cnt_reg - 1'b1;
               end
            end
            default: begin
               state_reg <= ST_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         ready_out <= 1'b1;
      end else begin
         ready_out <= (state_reg != ST_BUSY) &&
                      !(state_reg == ST_EXEC && (cmd_reg == pscp_pkg::CMD_SAVE ||
                        cmd_reg == pscp_pkg::CMD_NV_WRITE));
      end
   end

   // ***************************************************************
   // Serial shift path
   // ***************************************************************
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         shift_reg   <= '0;
         bit_cnt_reg <= 5'h00;
         sdo_bit_reg <= 1'b1;
      end else begin
         case (state_reg)
            ST_IDLE: begin
               if (cs_fall) begin
                  bit_cnt_reg <= 5'h00;
                  sdo_bit_reg <= shift_reg[pscp_pkg::WORD_BITS-1];
               end
            end
            ST_SHIFT: begin
               if (sclk_rise) begin
                  shift_reg <= {shift_reg[pscp_pkg::WORD_BITS-2:0], sdi_s};
                  // Count saturates so that a chained stream keeps the last word
                  if (bit_cnt_reg != pscp_pkg::FULL_COUNT) begin
                     bit_cnt_reg <= bit_cnt_reg + 5'h01;
                  end
               end else if (sclk_fall && bit_cnt_reg != 5'h00) begin
                  // Idle-high mode opens with a fall that must not shift
                  sdo_bit_reg <= shift_reg[pscp_pkg::WORD_BITS-1];
               end
            end
            ST_EXEC: begin
               bit_cnt_reg <= 5'h00;
               if (cmd_reg == pscp_pkg::CMD_RD_NV) begin
                  shift_reg[pscp_pkg::DATA_MSB:0] <= nv_reg[addr_reg];
               end else if (cmd_reg == pscp_pkg::CMD_RD_WIPER &&
                            pscp_wiper_addr_ok(cmd_reg, addr_reg)) begin
                  shift_reg[pscp_pkg::DATA_MSB:0] <= {6'h00, wiper_reg};
               end
            end
            default: begin
               bit_cnt_reg <= bit_cnt_reg;
            end
         endcase
      end
   end

   // Open drain: pull low only while selected and sending a zero
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         serial_out_pin_out    <= 1'b0;
         serial_out_pin_oe_out <= 1'b0;
      end else begin
         serial_out_pin_out    <= 1'b0;
         serial_out_pin_oe_out <= (state_reg == ST_SHIFT) && !cs_n_s && !sdo_bit_reg;
      end
   end

   // ***************************************************************
   // Command capture
   // ***************************************************************
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         cmd_reg       <= pscp_pkg::CMD_NOP;
         addr_reg      <= 4'h0;
         data_reg      <= 16'h0000;
         last_cmd_reg  <= pscp_pkg::CMD_NOP;
         repeat_ok_reg <= 1'b0;
      end else if (state_reg == ST_SHIFT && cs_rise) begin
         if (word_ok) begin
            cmd_reg  <= shift_reg[pscp_pkg::CMD_MSB:pscp_pkg::CMD_LSB];
            addr_reg <= shift_reg[pscp_pkg::ADDR_MSB:pscp_pkg::ADDR_LSB];
            data_reg <= shift_reg[pscp_pkg::DATA_MSB:0];
            last_cmd_reg  <= shift_reg[pscp_pkg::CMD_MSB:pscp_pkg::CMD_LSB];
            repeat_ok_reg <= pscp_is_step(shift_reg[pscp_pkg::CMD_MSB:pscp_pkg::CMD_LSB]) &&
                             pscp_wiper_addr_ok(shift_reg[pscp_pkg::CMD_MSB:pscp_pkg::CMD_LSB],
                                shift_reg[pscp_pkg::ADDR_MSB:pscp_pkg::ADDR_LSB]);
         end else if (bare_strobe) begin
            cmd_reg  <= last_cmd_reg;
            addr_reg <= 4'h0;
         end
      end
   end

   // ***************************************************************
   // Wiper and store
   // ***************************************************************
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         wiper_reg <= nv_reg[pscp_pkg::NV_WIPER_ADDR][pscp_pkg::WIPER_BITS-1:0];
      end else if (state_reg == ST_EXEC && pscp_wiper_addr_ok(cmd_reg, addr_reg)) begin
         // Step and shift commands never read data_reg
         case (cmd_reg)
            pscp_pkg::CMD_RESTORE, pscp_pkg::CMD_RESET: begin
               wiper_reg <= nv_reg[pscp_pkg::NV_WIPER_ADDR][pscp_pkg::WIPER_BITS-1:0];
            end
            pscp_pkg::CMD_SHR, pscp_pkg::CMD_SHR_ANY: begin
               wiper_reg <= wiper_reg >> 1;
            end
            pscp_pkg::CMD_DEC, pscp_pkg::CMD_DEC_ANY: begin
               if (wiper_reg != pscp_pkg::WIPER_ZERO) begin
                  wiper_reg <= wiper_reg - 10'h001;
               end
            end
            pscp_pkg::CMD_WR_WIPER: begin
               wiper_reg <= data_reg[pscp_pkg::WIPER_BITS-1:0];
            end
            pscp_pkg::CMD_SHL, pscp_pkg::CMD_SHL_ANY: begin
               if (wiper_reg == pscp_pkg::WIPER_ZERO) begin
                  wiper_reg <= pscp_pkg::WIPER_ONE;
               end else if (wiper_reg >= pscp_pkg::WIPER_MID) begin
                  wiper_reg <= pscp_pkg::WIPER_FULL;
               end else begin
                  wiper_reg <= {wiper_reg[8:0], 1'b0};
               end
            end
            pscp_pkg::CMD_INC, pscp_pkg::CMD_INC_ANY: begin
               if (wiper_reg != pscp_pkg::WIPER_FULL) begin
                  wiper_reg <= wiper_reg + 10'h001;
               end
            end
            default: begin
               wiper_reg <= wiper_reg;
            end
         endcase
      end
   end

   // Store models nonvolatile cells, so the ordinary reset leaves it alone
   always_ff @(posedge clk_in) begin
      if (factory_init_in) begin
         for (int i = 0; i < pscp_pkg::NV_WORDS; i++) begin
            nv_reg[i] <= pscp_pkg::NV_FACTORY;
         end
         nv_reg[pscp_pkg::NV_WIPER_ADDR] <= {6'h00, pscp_pkg::WIPER_FACTORY};
      end else if (state_reg == ST_EXEC && pscp_wiper_addr_ok(cmd_reg, addr_reg)) begin
         if (cmd_reg == pscp_pkg::CMD_SAVE) begin
            nv_reg[pscp_pkg::NV_WIPER_ADDR] <= {6'h00, wiper_reg};
         end else if (cmd_reg == pscp_pkg::CMD_NV_WRITE) begin
            nv_reg[addr_reg] <= data_reg;
         end
      end
   end

   // ***************************************************************
   // Status and latched outputs
   // ***************************************************************
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         read_program_out <= 1'b0;
      end else if (state_reg == ST_EXEC) begin
         if (cmd_reg == pscp_pkg::CMD_RESTORE && pscp_wiper_addr_ok(cmd_reg, addr_reg)) begin
            read_program_out <= 1'b1;
         end else if (cmd_reg == pscp_pkg::CMD_NOP) begin
            read_program_out <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         wiper_setting_out      <= pscp_pkg::WIPER_ZERO;
         latched_output_one_out <= 1'b0;
         latched_output_two_out <= 1'b0;
      end else begin
         wiper_setting_out      <= wiper_reg;
         latched_output_one_out <= nv_reg[pscp_pkg::NV_LATCH_ADDR][pscp_pkg::LATCH_ONE_BIT];
         latched_output_two_out <= nv_reg[pscp_pkg::NV_LATCH_ADDR][pscp_pkg::LATCH_TWO_BIT];
      end
   end
endmodule : pscp_top

/* File: sim/pscp_assertions.sv */
`timescale 1ns/1ps
module pscp_assertions #(
   parameter int unsigned SAVE_CYCLES = 20
) (
   input wire logic       clk_in,
   input wire logic       rst_in,
   input wire logic       factory_init_in,
   input wire logic       link_clk_in,
   input wire logic       chip_select_n_in,
   input wire logic       serial_in_pin_in,
   input wire logic       serial_out_pin_out,
   input wire logic       serial_out_pin_oe_out,
   input wire logic       ready_out,
   input wire logic       read_program_out,
   input wire logic [9:0] wiper_setting_out,
   input wire logic       latched_output_one_out,
   input wire logic       latched_output_two_out
);
   // ***************************************************************
   // Save lock length
   // ***************************************************************
   logic [31:0] busy_cnt_reg;
   always_ff @(posedge clk_in) begin
      if (rst_in || ready_out) begin
         busy_cnt_reg <= 32'h0;
      end else begin
         busy_cnt_reg <= busy_cnt_reg + 32'h1;
      end
   end
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (rst_in);
   // Long enough to outlast the input synchroniser and the output register
   sequence s_deselected;
      chip_select_n_in [*6];
   endsequence
   sequence s_selected;
      !chip_select_n_in [*8];
   endsequence
   a_out_low: assert property (serial_out_pin_out == 1'b0)
      else $error("serial out data not low");
   a_oe_released: assert property (s_deselected |-> !serial_out_pin_oe_out)
      else $error("serial out driven while deselected");
   a_wiper_frozen: assert property (s_selected |-> $stable(wiper_setting_out))
      else $error("wiper changed during a frame");
   a_wiper_at_exec: assert property ($changed(wiper_setting_out) |-> chip_select_n_in)
      else $error("wiper changed while selected");
   a_save_length: assert property ($rose(ready_out) |-> busy_cnt_reg == SAVE_CYCLES + 1)
      else $error("save lock length wrong");
   a_busy_min: assert property ($fell(ready_out) |-> !ready_out [*8])
      else $error("save lock too short");
   a_busy_frozen: assert property (!ready_out |-> $stable(wiper_setting_out))
      else $error("wiper changed during save");
   a_ready_cause: assert property ($fell(ready_out) |-> chip_select_n_in)
      else $error("save started while selected");
   a_rp_at_exec: assert property ($changed(read_program_out) |-> chip_select_n_in)
      else $error("read program state changed while selected");
   a_latch_at_exec: assert property ($changed({latched_output_one_out,
      latched_output_two_out}) |-> chip_select_n_in)
      else $error("latched output changed while selected");
   cover property ($rose(read_program_out));
endmodule : pscp_assertions

bind pscp_top pscp_assertions #(.SAVE_CYCLES(SAVE_CYCLES)) u_chk (
   .clk_in(clk_in), .rst_in(rst_in), .factory_init_in(factory_init_in),
   .link_clk_in(link_clk_in), .chip_select_n_in(chip_select_n_in),
   .serial_in_pin_in(serial_in_pin_in), .serial_out_pin_out(serial_out_pin_out),
   .serial_out_pin_oe_out(serial_out_pin_oe_out), .ready_out(ready_out),
   .read_program_out(read_program_out), .wiper_setting_out(wiper_setting_out),
   .latched_output_one_out(latched_output_one_out),
   .latched_output_two_out(latched_output_two_out)
);

/* File: sim/pscp_host_model.sv */
`timescale 1ns/1ps
module pscp_host_model (
   input  wire logic clk_in,
   input  wire logic serial_out_pin_oe_in,
   output logic      link_clk_out,
   output logic      chip_select_n_out,
   output logic      serial_in_pin_out
);
   // ***************************************************************
   // Host frame engine
   // ***************************************************************
   // Open-drain return line: pull-up wins unless the device pulls low
   wire logic line_level = !serial_out_pin_oe_in;
   initial begin
      link_clk_out      = 1'b0;
      chip_select_n_out = 1'b1;
      serial_in_pin_out = 1'b0;
   end
   task automatic tick(input int n);
      repeat (n) @(negedge clk_in);
   endtask : tick
   // Idle-high frames drop the clock before data, idle-low ones raise it after
   task automatic xfer(input logic [47:0] word, input int nbits, input bit idle_hi,
                       output logic [47:0] rx);
      rx = 48'h0;
      tick(1);
      link_clk_out = idle_hi;
      tick(1);
      chip_select_n_out = 1'b0;
      tick(8);
      for (int i = nbits - 1; i >= 0; i--) begin
         if (idle_hi) begin
            link_clk_out = 1'b0;
         end
         serial_in_pin_out = word[i];
         tick(4);
         link_clk_out = 1'b1;
         tick(4);
         // Sampled late in the bit so the slow open-drain edge has settled
         rx = {rx[46:0], line_level};
         if (!idle_hi) begin
            link_clk_out = 1'b0;
         end
      end
      tick(4);
      chip_select_n_out = 1'b1;
      // Deselected data line must not look like a stable bit
      serial_in_pin_out = ~serial_in_pin_out;
      tick(8);
   endtask : xfer
endmodule : pscp_host_model

/* File: sim/pot_serial_command_port_bench.sv */
`timescale 1ns/1ps
`define CHK(got, exp) begin \
   num_checks++; \
   if ((got) !== (exp)) begin \
      err_count++; \
      $display("unexpected at %0t: got %h expected %h", $time, (got), (exp)); \
   end \
end
module pot_serial_command_port_bench;
   logic        clk;
   logic        rst;
   logic        factory_init;
   logic        link_clk;
   logic        cs_n;
   logic        serial_in_pin;
   logic        serial_out_pin;
   logic        sdo_oe;
   logic        ready;
   logic        rp;
   logic [9:0]  wiper;
   logic        lat1;
   logic        lat2;
   logic [47:0] rx;
   int          err_count;
   int          num_checks;
   // Entries are bit count, expected wiper, word
   logic [65:0] tbl [0:11] = '{
      {8'h10, 10'h100, 48'h00b003},
      {8'h18, 10'h0ff, 48'h60ffff},
      {8'h00, 10'h0fe, 48'h000000},
      {8'h18, 10'h07f, 48'h400000},
      {8'h18, 10'h03f, 48'h5f1234},
      {8'h18, 10'h03f, 48'h420000},
      {8'h18, 10'h000, 48'hb00000},
      {8'h18, 10'h000, 48'h600000},
      {8'h18, 10'h000, 48'h400000},
      {8'h00, 10'h000, 48'h000000},
      {8'h18, 10'h000, 48'h0f3ff0},
      {8'h30, 10'h200, 48'hb003ffb00200}
   };
   pscp_top #(.SAVE_CYCLES(400)) i_dut (
      .clk_in(clk), .rst_in(rst), .factory_init_in(factory_init),
      .link_clk_in(link_clk), .chip_select_n_in(cs_n), .serial_in_pin_in(serial_in_pin),
      .serial_out_pin_out(serial_out_pin), .serial_out_pin_oe_out(sdo_oe), .ready_out(ready),
      .read_program_out(rp), .wiper_setting_out(wiper),
      .latched_output_one_out(lat1), .latched_output_two_out(lat2)
   );
   pscp_host_model i_host (
      .clk_in(clk), .serial_out_pin_oe_in(sdo_oe), .link_clk_out(link_clk),
      .chip_select_n_out(cs_n), .serial_in_pin_out(serial_in_pin)
   );
   // ***************************************************************
   // Access tasks and closing report
   // ***************************************************************
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   task automatic test_done;
      $display("checks %0d mismatches %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : test_done
   task automatic send(input logic [23:0] w, input bit mode);
      i_host.xfer({24'h0, w}, 24, mode, rx);
   endtask : send
   task automatic wait_ready;
      int n;
      n = 0;
      while (ready !== 1'b1 && n < 2000) begin
         @(negedge clk);
         n++;
      end
      if (ready !== 1'b1) begin
         err_count++;
         test_done;
      end
   endtask : wait_ready
   initial begin
      err_count = 0;
      num_checks = 0;
      factory_init = 1'b1;
      rst = 1'b1;
      repeat (10) @(negedge clk);
      factory_init = 1'b0;
      repeat (10) @(negedge clk);
      rst = 1'b0;
      repeat (4) @(negedge clk);
      `CHK(wiper, pscp_pkg::WIPER_FACTORY)
      `CHK({ready, rp, lat2, lat1}, 4'h8)
      send(24'hb00100, 1'b0);
      `CHK(wiper, 10'h100)
      send(24'h000000, 1'b1);
      `CHK(rx[23:0], 24'hb00100)
      for (int i = 0; i < 12; i++) begin
         i_host.xfer(tbl[i][47:0], int'(tbl[i][65:58]), i[0], rx);
         `CHK(wiper, tbl[i][57:48])
      end
      send(24'hb00155, 1'b0);
      send(24'h200000, 1'b1);
      `CHK(ready, 1'b0)
      send(24'hb00001, 1'b0);
      `CHK(wiper, 10'h155)
      wait_ready;
      send(24'hb00000, 1'b0);
      send(24'h100000, 1'b1);
      `CHK({rp, wiper}, 11'h555)
      send(24'h000000, 1'b0);
      `CHK(rp, 1'b0)
      send(24'h310003, 1'b1);
      wait_ready;
      `CHK({lat2, lat1}, 2'h3)
      send(24'h910000, 1'b0);
      send(24'h000000, 1'b1);
      `CHK(rx[23:0], 24'h910003)
      send(24'ha00000, 1'b1);
      send(24'h000000, 1'b0);
      `CHK(rx[23:0], 24'ha00155)
      rst = 1'b1;
      repeat (5) @(negedge clk);
      rst = 1'b0;
      repeat (4) @(negedge clk);
      `CHK({lat2, lat1, wiper}, 12'hd55)
      test_done;
   end
endmodule : pot_serial_command_port_bench
